// file: rtl/wsp_pkg.sv
// Package for the waveform sequence table player: register map, entry layout, codes.
// Assumes a single APB clock domain used as the sync clock (sample clock / 256).
package wsp_pkg;

  // Register byte offsets
  localparam logic [11:0] WSP_CTRL_OFF     = 12'h000;
  localparam logic [11:0] WSP_STATUS_OFF   = 12'h004;
  localparam logic [11:0] WSP_START_OFF    = 12'h008;
  localparam logic [11:0] WSP_TADDR_OFF    = 12'h00c;
  localparam logic [11:0] WSP_TW0_OFF      = 12'h010;
  localparam logic [11:0] WSP_TW1_OFF      = 12'h014;
  localparam logic [11:0] WSP_TW2_OFF      = 12'h018;
  localparam logic [11:0] WSP_TW3_OFF      = 12'h01c;
  localparam logic [11:0] WSP_INTLEN_OFF   = 12'h020;
  localparam logic [11:0] WSP_OFFLVL_OFF   = 12'h024;

  // Control bits
  localparam int WSP_CTRL_RUN_BIT  = 0;
  localparam int WSP_CTRL_SEQ_BIT  = 1;
  localparam int WSP_CTRL_INTP_BIT = 2;
  localparam int WSP_CTRL_EVT_BIT  = 3;

  // Word 0 fields
  localparam int WSP_W0_TYPE_LSB   = 0;
  localparam int WSP_W0_SADV_LSB   = 2;
  localparam int WSP_W0_QADV_LSB   = 4;
  localparam int WSP_W0_NEWSEQ_BIT = 6;
  localparam int WSP_W0_SCEND_BIT  = 7;
  localparam int WSP_W0_HOLDV_BIT  = 8;
  localparam int WSP_W0_SEG_LSB    = 16;
  // Word 1: segment loop [15:0], sequence loop [31:16]
  // Word 2: start offset [15:0], end offset [31:16] (end 0 = whole segment)
  // Word 3: hold or idle I [15:0], hold or idle Q [31:16]; idle delay uses segment loop field

  localparam logic [31:0] WSP_RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] WSP_INT_GRAN   = 16'h0080;
  localparam logic [15:0] WSP_SYNC_DIV   = 16'h0100;
  localparam logic [7:0]  WSP_IDLE_MIN   = 8'h01;

  typedef enum logic [1:0] {WSP_DATA, WSP_IDLE, WSP_EMPTY, WSP_RSVD} wsp_entry_type;
  typedef enum logic [1:0] {WSP_AUTO, WSP_COND, WSP_REPEAT, WSP_SINGLE} wsp_adv_type;

endpackage : wsp_pkg

// file: rtl/wsp_player.sv
// Waveform sequence table player with APB register access and a shared sequence table.
// Assumes pclk is the sync clock and the sample memory answers reads combinationally.
// What this block does
// - Data entry plays its referenced segment for its iteration count.
// - Idle entry outputs one programmed sample for a programmed, bounded delay.
// - Idle has no segment loop; as sequence head it still carries sequence loop.
// - Empty entry outputs nothing; the following entry starts a new sequence.
// - Auto and repeat segments repeat their loop count before their advancement rule applies.
// - Start and end offsets select part of a segment, at mode granularity.
// - Auto segment advance moves on after the last repetition.
// - Conditional segment repeats until event, then finishes current pass.
// - Repeat segment holds last value after all passes until an event.
// - Single segment plays one pass per event, holding between passes.
// - Auto sequence advance starts the next sequence at once.
// - Conditional sequence repeats until event, then completes current pass.
// - Repeat sequence holds last value after all passes until an event.
// - Single sequence plays one pass per event until count is used.
// - New-sequence flag marks an entry as the first of a sequence.
// - Scenario-end flag marks the last entry of the scenario.
// - Sequence head carries the sequence repeat count.
// - Interpolated mode idle holds separate I and Q samples.
// - All four channels start generation on the same cycle.
// - Internal-memory channels loop one segment of 128-multiple length forever.
// - Without sequencing each entry plays as a sequence of its own, its segment with its own loop count.
// - One table drives all channels; per-channel sample data may differ.
// - Held value comes from the entry, else from the offset level.
// - Sequencer and event sampling run on the sync clock, many samples per cycle.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
module wsp_player
  import wsp_pkg::*;
#(
  parameter int DEPTH  = 16,
  parameter int AW     = 4,
  parameter int GRAN   = 128
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        adv_event,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_seg,
  output logic [3:0]       ch_run,
  output logic             sample_valid,
  output logic             hold_valid,
  output logic [15:0]      hold_i,
  output logic [15:0]      hold_q,
  output logic             int_restart
);

  // Table depth must fill the pointer range, and one granule must fit a 16-bit address
  if (DEPTH != (1 << AW) || GRAN < 1 || GRAN > 65535)
  begin : g_bad_params
    $error("wsp_player: bad parameters");
  end

  localparam logic [15:0] GRAN16 = 16'(GRAN);

  typedef enum logic [2:0] {WSP_ST_STOP, WSP_ST_LOAD, WSP_ST_PLAY, WSP_ST_IDLE,
                            WSP_ST_SEG_WAIT, WSP_ST_SEQ_WAIT, WSP_ST_INT} wsp_state_type;

  typedef struct packed {
    logic [31:0]   ctrl;
    logic [AW-1:0] start;
    logic [AW-1:0] taddr;
    logic [31:0]   intlen;
    logic [15:0]   offlvl;
    wsp_state_type st;
    logic [AW-1:0] ptr;
    logic [AW-1:0] seq_head;
    logic [15:0]   addr;
    logic [15:0]   seg_cnt;
    logic [15:0]   seq_cnt;
    logic          seg_evt;
    logic          seq_evt;
    logic          evt_d;
    logic [31:0]   rdata;
    logic          valid;
    logic          hold;
    logic [15:0]   hi;
    logic [15:0]   hq;
    logic          restart;
  } wsp_regs_type;

  wsp_regs_type r;
  wsp_regs_type next_r;
  logic [31:0]  tab [DEPTH][4];

  logic          wr;
  logic          rd;
  logic [31:0]   w0, w1, w2, w3;
  wsp_entry_type etype;
  wsp_adv_type   sadv, qadv;
  logic [15:0]   seg_end;
  logic          evt;
  logic          pass_end;
  logic          seq_last;
  logic [AW-1:0] nxt;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign w0 = tab[r.ptr][0];
  assign w1 = tab[r.ptr][1];
  assign w2 = tab[r.ptr][2];
  assign w3 = tab[r.ptr][3];
  assign etype = wsp_entry_type'(w0[WSP_W0_TYPE_LSB +: 2]);
  assign sadv  = wsp_adv_type'(w0[WSP_W0_SADV_LSB +: 2]);
  assign qadv  = wsp_adv_type'(tab[r.seq_head][0][WSP_W0_QADV_LSB +: 2]);
  assign seg_end = (w2[31:16] != 16'h0000) ? w2[31:16] : 16'hffff;
  assign evt = adv_event && !r.evt_d;
  // One extra bit so the last granule below 64K still ends a full-length pass
  assign pass_end = ({1'b0, r.addr} + {1'b0, GRAN16} >= {1'b0, seg_end});
  assign nxt = r.ptr + 1'b1;
  // Sequence ends at scenario end, before a new-sequence entry, before an empty one, or at every entry without sequencing
  assign seq_last = w0[WSP_W0_SCEND_BIT] || tab[nxt][0][WSP_W0_NEWSEQ_BIT]
                    || (tab[nxt][0][WSP_W0_TYPE_LSB +: 2] == 2'(WSP_EMPTY))
                    || !r.ctrl[WSP_CTRL_SEQ_BIT];

  // Table storage, one table for every channel
  always_ff @(posedge pclk)
  begin
    if (wr && paddr >= WSP_TW0_OFF && paddr <= WSP_TW3_OFF)
      tab[r.taddr][paddr[3:2]] <= pwdata;
  end

  always_comb
  begin
    next_r = r;
    next_r.evt_d = adv_event;
    next_r.restart = 1'b0;
    if (evt)
    begin
      next_r.seg_evt = 1'b1;
      next_r.seq_evt = 1'b1;
    end
    // APB writes
    if (wr)
    begin
      if (paddr == WSP_CTRL_OFF)
        next_r.ctrl = pwdata;
      else if (paddr == WSP_START_OFF)
        next_r.start = pwdata[AW-1:0];
      else if (paddr == WSP_TADDR_OFF)
        next_r.taddr = pwdata[AW-1:0];
      else if (paddr == WSP_INTLEN_OFF)
        next_r.intlen = pwdata;
      else if (paddr == WSP_OFFLVL_OFF)
        next_r.offlvl = pwdata[15:0];
    end
    if (rd)
    begin
      if (paddr == WSP_CTRL_OFF)
        next_r.rdata = r.ctrl;
      else if (paddr == WSP_STATUS_OFF)
        next_r.rdata = {8'h00, 5'h00, r.st, 12'h000, 4'(r.ptr)};
      else if (paddr == WSP_START_OFF)
        next_r.rdata = 32'(r.start);
      else if (paddr == WSP_TADDR_OFF)
        next_r.rdata = 32'(r.taddr);
      else if (paddr >= WSP_TW0_OFF && paddr <= WSP_TW3_OFF)
        next_r.rdata = tab[r.taddr][paddr[3:2]];
      else if (paddr == WSP_INTLEN_OFF)
        next_r.rdata = r.intlen;
      else if (paddr == WSP_OFFLVL_OFF)
        next_r.rdata = {16'h0000, r.offlvl};
      else
        next_r.rdata = WSP_RESET_WORD;
    end

    case (r.st)
      WSP_ST_STOP:
      begin
        next_r.valid = 1'b0;
        next_r.hold = 1'b0;
        if (r.ctrl[WSP_CTRL_RUN_BIT])
        begin
          next_r.ptr = r.start;
          next_r.seq_head = r.start;
          next_r.seq_cnt = 16'h0000;
          next_r.seg_evt = 1'b0;
          next_r.seq_evt = 1'b0;
          next_r.st = WSP_ST_LOAD;
        end
      end
      WSP_ST_LOAD:
      begin
        next_r.addr = w2[15:0];
        next_r.seg_cnt = 16'h0000;
        next_r.seg_evt = 1'b0;
        if (r.ptr == r.seq_head && r.seq_cnt == 16'h0000)
          next_r.seq_evt = 1'b0;
        if (etype == WSP_EMPTY)
        begin
          next_r.ptr = nxt;
          next_r.seq_head = nxt;
          next_r.seq_cnt = 16'h0000;
        end
        else if (etype == WSP_IDLE)
        begin
          next_r.hi = w3[15:0];
          next_r.hq = r.ctrl[WSP_CTRL_INTP_BIT] ? w3[31:16] : w3[15:0];
          next_r.hold = 1'b1;
          next_r.valid = 1'b0;
          next_r.st = WSP_ST_IDLE;
        end
        else
        begin
          next_r.hold = 1'b0;
          next_r.valid = 1'b1;
          next_r.st = WSP_ST_PLAY;
        end
      end
      WSP_ST_IDLE:
      begin
        // Idle delay counts sync cycles; at least the minimum is spent
        next_r.seg_cnt = r.seg_cnt + 16'h0001;
        if (r.seg_cnt + 16'h0001 >= w1[15:0] && r.seg_cnt + 16'h0001 >= 16'(WSP_IDLE_MIN))
          next_r.st = WSP_ST_SEG_WAIT;
      end
      WSP_ST_PLAY:
      begin
        next_r.addr = r.addr + GRAN16;
        if (pass_end)
        begin
          next_r.addr = w2[15:0];
          next_r.seg_cnt = r.seg_cnt + 16'h0001;
          case (sadv)
            WSP_AUTO:
              if (r.seg_cnt + 16'h0001 >= w1[15:0])
                next_r.st = WSP_ST_SEG_WAIT;
            WSP_COND:
              if (r.seg_evt || evt)
                next_r.st = WSP_ST_SEG_WAIT;
            WSP_REPEAT:
              if (r.seg_cnt + 16'h0001 >= w1[15:0])
              begin
                next_r.valid = 1'b0;
                next_r.hold = 1'b1;
                next_r.seg_evt = 1'b0;
                next_r.st = WSP_ST_SEG_WAIT;
              end
            default:
            begin
              next_r.valid = 1'b0;
              next_r.hold = 1'b1;
              next_r.seg_evt = 1'b0;
              next_r.st = WSP_ST_SEG_WAIT;
            end
          endcase
          next_r.hi = w0[WSP_W0_HOLDV_BIT] ? w3[15:0] : r.offlvl;
          next_r.hq = w0[WSP_W0_HOLDV_BIT] ? w3[31:16] : r.offlvl;
        end
      end
      WSP_ST_SEG_WAIT:
      begin
        // Repeat and single wait for an event arriving after the hold began
        if (r.hold && etype == WSP_DATA && !(r.seg_evt || evt))
          next_r.st = WSP_ST_SEG_WAIT;
        else if (etype == WSP_DATA && sadv == WSP_SINGLE && r.seg_cnt < w1[15:0])
        begin
          next_r.hold = 1'b0;
          next_r.valid = 1'b1;
          next_r.st = WSP_ST_PLAY;
        end
        else if (!seq_last)
        begin
          next_r.ptr = nxt;
          next_r.st = WSP_ST_LOAD;
        end
        else
        begin
          next_r.seq_cnt = r.seq_cnt + 16'h0001;
          next_r.st = WSP_ST_SEQ_WAIT;
        end
      end
      WSP_ST_INT:
      begin
        // Stays here until run is cleared; addressing is handled below
        next_r.st = WSP_ST_INT;
      end
      default:
      begin
        // WSP_ST_SEQ_WAIT: sequence-level advancement at the sequence's last entry
        next_r.ptr = r.seq_head;
        next_r.st = WSP_ST_LOAD;
        case (qadv)
          WSP_AUTO:
            if (r.seq_cnt >= tab[r.seq_head][1][31:16])
              next_r.seq_cnt = 16'h0000;
          WSP_COND:
            if (r.seq_evt)
              next_r.seq_cnt = 16'h0000;
          WSP_REPEAT:
            if (r.seq_cnt >= tab[r.seq_head][1][31:16])
            begin
              next_r.hold = 1'b1;
              next_r.valid = 1'b0;
              next_r.st = WSP_ST_SEQ_WAIT;
              if (evt)
              begin
                next_r.seq_cnt = 16'h0000;
                next_r.st = WSP_ST_LOAD;
              end
            end
          default:
          begin
            next_r.hold = 1'b1;
            next_r.valid = 1'b0;
            next_r.st = WSP_ST_SEQ_WAIT;
            if (evt)
            begin
              next_r.st = WSP_ST_LOAD;
              if (r.seq_cnt >= tab[r.seq_head][1][31:16])
                next_r.seq_cnt = 16'h0000;
            end
          end
        endcase
        if (next_r.st == WSP_ST_LOAD && next_r.seq_cnt == 16'h0000)
        begin
          if (w0[WSP_W0_SCEND_BIT])
            next_r.ptr = r.start;
          else
            next_r.ptr = nxt;
          next_r.seq_head = next_r.ptr;
        end
      end
    endcase

    // Internal-memory path: one segment looped forever, granularity 128
    if (r.st == WSP_ST_STOP && r.ctrl[WSP_CTRL_RUN_BIT] && r.intlen[31])
      next_r.st = WSP_ST_INT;
    if (r.st == WSP_ST_INT)
    begin
      next_r.valid = 1'b1;
      next_r.addr = r.addr + WSP_INT_GRAN;
      if (r.addr + WSP_INT_GRAN >= r.intlen[15:0])
      begin
        next_r.addr = 16'h0000;
        next_r.restart = 1'b1;
      end
    end
    // Outputs drop with the stop, so nothing is shown while channels are halted
    if (!r.ctrl[WSP_CTRL_RUN_BIT])
    begin
      next_r.st = WSP_ST_STOP;
      next_r.valid = 1'b0;
      next_r.hold = 1'b0;
      next_r.restart = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign prdata       = r.rdata;
  assign mem_addr     = r.addr;
  assign mem_seg      = (r.st == WSP_ST_INT) ? 16'h0000 : w0[WSP_W0_SEG_LSB +: 16];
  assign ch_run       = {4{r.st != WSP_ST_STOP}};
  assign sample_valid = r.valid;
  assign hold_valid   = r.hold;
  assign hold_i       = r.hi;
  assign hold_q       = r.hq;
  assign int_restart  = r.restart;

endmodule : wsp_player

// file: tb/wsp_event_src.sv
// Partner model: the advancement-event source feeding adv_event.
// Assumes the bench pulses fire for one pclk cycle, driven just after a rising edge.
module wsp_event_src
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  output logic      adv_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] left;
  // Two-cycle level so the player's edge detector always sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      left <= 2'h0;
    else if (fire)
      left <= 2'h2;
    else if (left != 2'h0)
      left <= left - 2'h1;
  end
  assign adv_event = (left != 2'h0);
endmodule : wsp_event_src

// file: tb/wsp_player_assertions.sv
// Checker for the player's ports: assertions and covers.
// Assumes one pclk domain and the active-low asynchronous presetn.
module wsp_player_checker
  import wsp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adv_event,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_seg,
  input wire logic [3:0]  ch_run,
  input wire logic        sample_valid,
  input wire logic        hold_valid,
  input wire logic [15:0] hold_i,
  input wire logic [15:0] hold_q,
  input wire logic        int_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ch_same; ch_run == 4'h0 || ch_run == 4'hf; endproperty
  a_ch_same: assert property (p_ch_same)
    else $error("channels not started together");
  property p_restart_run; int_restart |-> ch_run == 4'hf; endproperty
  a_restart_run: assert property (p_restart_run)
    else $error("segment wrap while stopped");
  property p_excl; !(sample_valid && hold_valid); endproperty
  a_excl: assert property (p_excl)
    else $error("playing and holding at once");
  property p_hold_stable; hold_valid && $past(hold_valid) |-> $stable(hold_i) && $stable(hold_q);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("held value changed during hold");
  property p_play_run; sample_valid |-> ch_run == 4'hf; endproperty
  a_play_run: assert property (p_play_run)
    else $error("samples played while stopped");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("access phase stalled");
  property p_no_err; psel && penable |-> !pslverr; endproperty
  a_no_err: assert property (p_no_err)
    else $error("slave error raised");
  property p_unmapped; psel && !penable && !pwrite && paddr > 12'h024 |=> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  c_hold: cover property ($rose(hold_valid));
  c_wrap: cover property (int_restart);
  c_event: cover property (hold_valid ##1 adv_event);
endmodule : wsp_player_checker

bind wsp_player wsp_player_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .adv_event(adv_event), .mem_addr(mem_addr),
  .mem_seg(mem_seg), .ch_run(ch_run), .sample_valid(sample_valid), .hold_valid(hold_valid),
  .hold_i(hold_i), .hold_q(hold_q), .int_restart(int_restart));

// file: tb/test_waveform_sequence_table_player.sv
// Self-checking bench for the player: register rows, then idle, repeat, single and internal cases.
// Assumes APB offsets from wsp_pkg; the cycle ceiling ends any hung wait.
`define CHK(nm, e, g) \
  begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_waveform_sequence_table_player
  import wsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} wsp_row_type;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        fire    = 1'b0;
  logic [11:0] paddr   = 12'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, adv_event, sample_valid, hold_valid, int_restart;
  logic [15:0] mem_addr, mem_seg, hold_i, hold_q;
  logic [3:0]  ch_run;
  int          n_errors, checks, cyc, k, i;
  wsp_row_type rows [5] = '{'{WSP_CTRL_OFF, 32'h6, 32'h6}, '{WSP_TADDR_OFF, 32'h3, 32'h3},
    '{WSP_START_OFF, 32'h2, 32'h2}, '{WSP_OFFLVL_OFF, 32'h200, 32'h200},
    '{12'h100, 32'h5, 32'h0}};

  always #20 pclk = ~pclk;

  wsp_player #(.DEPTH(16), .AW(4), .GRAN(128)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adv_event(adv_event),
    .mem_addr(mem_addr), .mem_seg(mem_seg), .ch_run(ch_run), .sample_valid(sample_valid),
    .hold_valid(hold_valid), .hold_i(hold_i), .hold_q(hold_q), .int_restart(int_restart));

  wsp_event_src u_evt (.pclk(pclk), .presetn(presetn), .fire(fire), .adv_event(adv_event));

  task automatic summarize();
  begin
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask : summarize

  // Ceiling well above the few hundred cycles the cases need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
  begin
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask : apb

  // Held mid-run too, so ch_run, sample_valid, hold_valid and prdata are checked cleared on every reset
  task automatic do_reset();
  begin
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK("ch_run", 4'h0, ch_run)
    `CHK("sample_valid", 1'b0, sample_valid)
    `CHK("hold_valid", 1'b0, hold_valid)
    `CHK("prdata", 32'h0, prdata)
    presetn <= 1'b1;
    @(posedge pclk);
  end
  endtask : do_reset

  task automatic load(input logic [31:0] w0, w1, w2, w3);
  begin
    apb(1'b1, WSP_TADDR_OFF, 32'h0);
    apb(1'b1, WSP_TW0_OFF, w0);
    apb(1'b1, WSP_TW1_OFF, w1);
    apb(1'b1, WSP_TW2_OFF, w2);
    apb(1'b1, WSP_TW3_OFF, w3);
    apb(1'b1, WSP_START_OFF, 32'h0);
  end
  endtask : load

  initial
  begin
    cyc = 0;
    n_errors = 0;
    checks = 0;
    do_reset();
    foreach (rows[r])
    begin
      apb(1'b1, rows[r].a, rows[r].d);
      apb(1'b0, rows[r].a, 32'h0);
      `CHK("readback", rows[r].e, q)
    end
    $display("register rows done");
    // Idle head entry in interpolated mode, one sequence pass
    do_reset();
    load(32'h0000_00c1, 32'h0001_0003, 32'h0, 32'h5678_1234);
    apb(1'b1, WSP_CTRL_OFF, 32'h7);
    for (i = 0; i < 300 && hold_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("idle hold", 1'b1, hold_valid)
    `CHK("idle i", 16'h1234, hold_i)
    `CHK("idle q", 16'h5678, hold_q)
    `CHK("sample_valid", 1'b0, sample_valid)
    $display("idle entry done");
    // Data entry, repeat advance, two loops, partial segment of one granule from 0x80
    do_reset();
    load(32'h0005_01c8, 32'h0001_0002, 32'h0100_0080, 32'h0000_0abc);
    apb(1'b1, WSP_CTRL_OFF, 32'h3);
    for (i = 0; i < 300 && sample_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("segment", 16'h0005, mem_seg)
    `CHK("start offset", 16'h0080, mem_addr)
    `CHK("ch_run", 4'hf, ch_run)
    for (i = 0; i < 300 && hold_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("hold value", 16'h0abc, hold_i)
    k = 0;
    repeat (20) @(posedge pclk) k = k + int'(hold_valid === 1'b1);
    `CHK("hold cycles", 20, k)
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    for (i = 0; i < 50 && sample_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("resume", 1'b1, sample_valid)
    $display("repeat advance done");
    // Single advance: one pass per event, offset level held between passes
    do_reset();
    load(32'h0005_00cc, 32'h0001_0002, 32'h0100_0080, 32'h0);
    apb(1'b1, WSP_OFFLVL_OFF, 32'h0321);
    apb(1'b1, WSP_CTRL_OFF, 32'h3);
    for (i = 0; i < 300 && hold_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("offset hold", 16'h0321, hold_i)
    repeat (5) @(posedge pclk);
    `CHK("single wait", 1'b0, sample_valid)
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    for (i = 0; i < 50 && sample_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("next pass", 1'b1, sample_valid)
    for (i = 0; i < 50 && hold_valid !== 1'b1; i++) @(posedge pclk);
    `CHK("held again", 1'b1, hold_valid)
    repeat (5) @(posedge pclk);
    `CHK("still held", 1'b0, sample_valid)
    $display("single advance done");
    // Internal memory: one segment of two granules loops until reset
    do_reset();
    apb(1'b1, WSP_INTLEN_OFF, 32'h8000_0100);
    apb(1'b1, WSP_CTRL_OFF, 32'h1);
    k = 0;
    repeat (40) @(posedge pclk) k = k + int'(int_restart === 1'b1);
    `CHK("wraps seen", 1'b1, k > 1)
    `CHK("ch_run", 4'hf, ch_run)
    do_reset();
    $display("internal loop done");
    summarize();
  end
endmodule : test_waveform_sequence_table_player
